// ===== pbm_pkg.sv
// Shared constants and types for the power bank mode controller
package pbm_pkg;
  localparam int CLK_HZ          = 125_000_000;
  // Long press time in milliseconds
  localparam int LONG_PRESS_MS   = 2000;
  localparam int LONG_PRESS_CYC  = (CLK_HZ / 1000) * LONG_PRESS_MS;
  // Settling time for the internal rail before a path switch closes, in microseconds
  localparam int RAIL_SETTLE_US  = 100;
  localparam int RAIL_SETTLE_CYC = (CLK_HZ / 1_000_000) * RAIL_SETTLE_US;
  localparam int CNT_W           = 32;

  // Boost voltage selection
  localparam logic [1:0] VSEL_5V   = 2'h0;
  localparam logic [1:0] VSEL_9V   = 2'h1;
  localparam logic [1:0] VSEL_12V  = 2'h2;
  localparam logic [1:0] VSEL_CONT = 2'h3;

  // Firmware variant select
  localparam logic FW_DUAL_A = 1'h0;
  localparam logic FW_TYPE_C = 1'h1;

  typedef enum logic [1:0] {
    PBM_LOWPWR = 2'b00,
    PBM_BUCK   = 2'b01,
    PBM_RAMP   = 2'b10,
    PBM_BOOST  = 2'b11
  } pbm_mode_t;
endpackage

// ===== pbm_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module pbm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] sync
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } pbm_sync_state_t;

  pbm_sync_state_t st;
  pbm_sync_state_t next_st;

  if (W < 1) begin : gBadWidth
    $error("pbm_sync width must be positive");
  end

  always_comb begin
    next_st.first  = async;
    next_st.second = st.first;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync = st.second;
endmodule

// ===== pbm_button.sv
// Push-button press classifier: long or short press by high time
`timescale 1ns/1ns
module pbm_button #(
  parameter int LONG_CYC = pbm_pkg::LONG_PRESS_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Synchronised button level
  input  wire logic button,
  // Press events
  output logic      longPress,
  output logic      shortPress
);
  typedef struct packed {
    logic [pbm_pkg::CNT_W-1:0] count;
    logic                      seenLong;
    logic                      longPress;
    logic                      shortPress;
  } pbm_button_state_t;

  pbm_button_state_t st;
  pbm_button_state_t next_st;

  if (LONG_CYC < 1) begin : gBadLong
    $error("pbm_button long press count must be positive");
  end

  always_comb begin
    next_st            = st;
    next_st.longPress  = 1'b0;
    next_st.shortPress = 1'b0;
    if (button) begin
      if (!st.seenLong) begin
        next_st.count = st.count + 32'h1;
        // Fire as soon as the high time passes the limit so wake is not delayed
        if (st.count >= LONG_CYC[pbm_pkg::CNT_W-1:0]) begin
          next_st.longPress = 1'b1;
          next_st.seenLong  = 1'b1;
        end
      end
    end else begin
      next_st.shortPress = (st.count != '0) && !st.seenLong;
      next_st.count      = '0;
      next_st.seenLong   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign longPress  = st.longPress;
  assign shortPress = st.shortPress;
endmodule

// ===== pbm_mode_ctrl.sv
// Power bank mode controller: low power, buck and boost sequencing
`timescale 1ns/1ns
module pbm_mode_ctrl #(
  parameter int LONG_CYC   = pbm_pkg::LONG_PRESS_CYC,
  parameter int SETTLE_CYC = pbm_pkg::RAIL_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Firmware variant, static
  input  wire logic       typeCFirmware,
  // Input port and analog comparators
  input  wire logic       inputPlugPresent,
  input  wire logic       aboveWakeDetect,
  input  wire logic       aboveUndervoltage,
  // Output plug sense and current
  input  wire logic       firstOutputSense,
  input  wire logic       secondOutputSense,
  input  wire logic       firstBelowTermCurrent,
  input  wire logic       secondBelowTermCurrent,
  // Battery
  input  wire logic       batteryLow,
  // Push button
  input  wire logic       button,
  // Port control IC status
  input  wire logic       portAttachedSink,
  input  wire logic       portAttachedSource,
  // Fast charge voltage request from the portable device
  input  wire logic [1:0] fastChargeRequest,
  // Rail and supply status from the boost converter
  input  wire logic       railReady,
  // Mode outputs
  output logic            operating,
  output logic            buckEnable,
  output logic            boostEnable,
  output logic [1:0]      boostVoltage,
  output logic            firstPathEnable,
  output logic            secondPathEnable,
  output logic            externalBoosterEnable,
  output logic            fastChargeEnable
);
  // The variant strap is a pin too, so it crosses with the rest
  localparam int NSYNC = 15;

  typedef struct packed {
    pbm_pkg::pbm_mode_t        mode;
    logic [pbm_pkg::CNT_W-1:0] settle;
    logic                      firstActive;
    logic                      secondActive;
    logic                      firstLatched;
    logic                      secondLatched;
    logic                      buck;
    logic                      boost;
    logic [1:0]                vsel;
    logic                      path1;
    logic                      path2;
    logic                      extBoost;
    logic                      fastChg;
  } pbm_state_t;

  pbm_state_t st;
  pbm_state_t next_st;

  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncIn;
  logic             fwTypeC;
  logic             longPress;
  logic             inPlug;
  logic             inWake;
  logic             inUv;
  logic             out1;
  logic             out2;
  logic             term1;
  logic             term2;
  logic             batLow;
  logic             btnLevel;
  logic             atSnk;
  logic             atSrc;
  logic [1:0]       fcReq;
  logic             railOk;
  logic             buckWanted;
  logic             want1;
  logic             want2;
  logic             stop1;
  logic             stop2;

  if (SETTLE_CYC < 1) begin : gBadSettle
    $error("pbm_mode_ctrl settle count must be positive");
  end
  if (LONG_CYC < 1) begin : gBadLong
    $error("pbm_mode_ctrl long press count must be positive");
  end

  assign rawIn = {typeCFirmware, inputPlugPresent, aboveWakeDetect, aboveUndervoltage,
                  firstOutputSense, secondOutputSense, firstBelowTermCurrent,
                  secondBelowTermCurrent, batteryLow, button, portAttachedSink,
                  portAttachedSource, fastChargeRequest, railReady};

  // Every pin level crosses in through two flops
  pbm_sync #(
    .W(NSYNC)
  ) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .async(rawIn),
    .sync (syncIn)
  );

  assign {fwTypeC, inPlug, inWake, inUv, out1, out2, term1, term2, batLow, btnLevel,
          atSnk, atSrc, fcReq, railOk} = syncIn;

  pbm_button #(
    .LONG_CYC(LONG_CYC)
  ) u_button (
    .clk       (clk),
    .rst_n     (rst_n),
    .button    (btnLevel),
    .longPress (longPress),
    .shortPress()
  );

  // Buck source: dual-A plug above undervoltage, or Type-C port IC attached as sink above undervoltage
  always_comb begin
    if (fwTypeC == pbm_pkg::FW_TYPE_C) begin
      buckWanted = atSnk && inUv;
      want1      = atSrc;
    end else begin
      buckWanted = inPlug && inUv;
      want1      = out1;
    end
    want2 = out2;
    // A stopped port needs its plug removed, a long press, or a low-power wake by the other plug before it may restart
    stop1 = !want1 || term1 || batLow;
    stop2 = !want2 || term2 || batLow;
  end

  always_comb begin
    next_st = st;
    if (!want1) begin
      next_st.firstLatched = 1'b0;
    end
    if (!want2) begin
      next_st.secondLatched = 1'b0;
    end
    case (st.mode)
      pbm_pkg::PBM_LOWPWR: begin
        next_st.buck     = 1'b0;
        next_st.boost    = 1'b0;
        next_st.path1    = 1'b0;
        next_st.path2    = 1'b0;
        next_st.extBoost = 1'b0;
        next_st.fastChg  = 1'b0;
        next_st.vsel     = pbm_pkg::VSEL_5V;
        if (buckWanted) begin
          next_st.mode = pbm_pkg::PBM_BUCK;
        end else if (fwTypeC == pbm_pkg::FW_DUAL_A && inPlug && inWake) begin
          next_st.mode = pbm_pkg::PBM_BUCK;
        end else if (!batLow && ((want1 && !st.firstLatched) || (want2 && !st.secondLatched)
                                 || longPress)) begin
          // Long press restarts any present plug, even one stopped earlier
          next_st.mode         = pbm_pkg::PBM_RAMP;
          next_st.firstActive  = want1;
          next_st.secondActive = want2;
          next_st.boost        = 1'b1;
          next_st.settle       = '0;
        end
      end
      pbm_pkg::PBM_BUCK: begin
        next_st.buck = buckWanted;
        if (fwTypeC == pbm_pkg::FW_DUAL_A && !inPlug) begin
          next_st.mode = pbm_pkg::PBM_LOWPWR;
          next_st.buck = 1'b0;
        end else if (fwTypeC == pbm_pkg::FW_TYPE_C && !atSnk) begin
          next_st.mode = pbm_pkg::PBM_LOWPWR;
          next_st.buck = 1'b0;
        end
      end
      pbm_pkg::PBM_RAMP: begin
        // Rail must reach 5 V and settle before any path switch closes
        next_st.vsel = pbm_pkg::VSEL_5V;
        if (buckWanted || batLow) begin
          next_st.mode  = buckWanted ? pbm_pkg::PBM_BUCK : pbm_pkg::PBM_LOWPWR;
          next_st.boost = 1'b0;
        end else if (railOk) begin
          next_st.settle = st.settle + 32'h1;
          if (st.settle >= SETTLE_CYC[pbm_pkg::CNT_W-1:0] - 32'h1) begin
            next_st.mode     = pbm_pkg::PBM_BOOST;
            next_st.path1    = st.firstActive;
            next_st.path2    = st.secondActive;
            next_st.extBoost = st.secondActive;
            next_st.fastChg  = st.firstActive;
          end
        end else begin
          next_st.settle = '0;
        end
      end
      pbm_pkg::PBM_BOOST: begin
        // A long press clears the stop latches so plugs still present rejoin
        if (longPress) begin
          next_st.firstLatched  = 1'b0;
          next_st.secondLatched = 1'b0;
        end
        // Late plug joins without a new ramp, but only once the rail is back at 5 V
        if (want2 && !st.secondActive && !st.secondLatched && !batLow
            && st.vsel == pbm_pkg::VSEL_5V) begin
          next_st.secondActive = 1'b1;
          next_st.path2        = 1'b1;
          next_st.extBoost     = 1'b1;
        end else if (st.secondActive && stop2) begin
          next_st.secondActive  = 1'b0;
          next_st.secondLatched = want2;
          next_st.path2         = 1'b0;
          next_st.extBoost      = 1'b0;
        end
        if (want1 && !st.firstActive && !st.firstLatched && !batLow) begin
          next_st.firstActive = 1'b1;
          next_st.path1       = 1'b1;
          next_st.fastChg     = 1'b1;
        end else if (st.firstActive && stop1) begin
          next_st.firstActive  = 1'b0;
          next_st.firstLatched = want1;
          next_st.path1        = 1'b0;
          next_st.fastChg      = 1'b0;
        end
        // Fast charge negotiation only when the integrated port is alone; a waiting
        // plug pulls the rail back to 5 V before its path may close
        if (st.firstActive && !st.secondActive && !(want2 && !st.secondLatched)) begin
          next_st.vsel = fcReq;
        end else begin
          next_st.vsel = pbm_pkg::VSEL_5V;
        end
        if (buckWanted || (fwTypeC == pbm_pkg::FW_DUAL_A && inPlug)) begin
          next_st.mode         = pbm_pkg::PBM_BUCK;
          next_st.boost        = 1'b0;
          next_st.path1        = 1'b0;
          next_st.path2        = 1'b0;
          next_st.extBoost     = 1'b0;
          next_st.fastChg      = 1'b0;
          next_st.firstActive  = 1'b0;
          next_st.secondActive = 1'b0;
          next_st.vsel         = pbm_pkg::VSEL_5V;
        end else if (batLow || ((!st.firstActive || stop1) && (!st.secondActive || stop2))) begin
          next_st.mode         = pbm_pkg::PBM_LOWPWR;
          next_st.boost        = 1'b0;
          next_st.path1        = 1'b0;
          next_st.path2        = 1'b0;
          next_st.extBoost     = 1'b0;
          next_st.fastChg      = 1'b0;
          next_st.firstActive  = 1'b0;
          next_st.secondActive = 1'b0;
          next_st.firstLatched  = want1;
          next_st.secondLatched = want2;
          next_st.vsel         = pbm_pkg::VSEL_5V;
        end
      end
      default: begin
        next_st = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign operating             = (st.mode != pbm_pkg::PBM_LOWPWR);
  assign buckEnable            = st.buck;
  assign boostEnable           = st.boost;
  assign boostVoltage          = st.vsel;
  assign firstPathEnable       = st.path1;
  assign secondPathEnable      = st.path2;
  assign externalBoosterEnable = st.extBoost;
  assign fastChargeEnable      = st.fastChg;
endmodule

// ===== pbm_mode_ctrl_properties.sv
// Concurrent checks on the mode controller ports
`timescale 1ns/1ns
module pbm_mode_props #(
  parameter int LONG_CYC   = 20,
  parameter int SETTLE_CYC = 4
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Inputs
  input wire logic       inputPlugPresent,
  input wire logic       aboveUndervoltage,
  input wire logic       secondOutputSense,
  input wire logic       batteryLow,
  input wire logic       railReady,
  // Outputs
  input wire logic       operating,
  input wire logic       buckEnable,
  input wire logic       boostEnable,
  input wire logic [1:0] boostVoltage,
  input wire logic       firstPathEnable,
  input wire logic       secondPathEnable,
  input wire logic       externalBoosterEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_sleep_quiet: assert property (!operating |-> !(buckEnable || boostEnable ||
    firstPathEnable || secondPathEnable || externalBoosterEnable))
    else $error("outputs active in low power");
  chk_active_operating: assert property ((buckEnable || boostEnable) |-> operating)
    else $error("charging without operating mode");
  chk_rail_first: assert property ($rose(firstPathEnable || secondPathEnable) |->
    railReady && $past(boostEnable, 4))
    else $error("path closed before rail settled");
  chk_booster_plug: assert property ($rose(externalBoosterEnable) |->
    $past(secondOutputSense, 3) && railReady)
    else $error("booster enabled without second plug");
  chk_plug_wakes: assert property ($rose(secondOutputSense) && !operating && !batteryLow &&
    !aboveUndervoltage && !inputPlugPresent |-> ##[1:5] boostEnable)
    else $error("second plug did not start boost");
  chk_buck_excl: assert property (buckEnable |-> !boostEnable)
    else $error("buck and boost together");
  chk_buck_uv: assert property ($rose(buckEnable) |-> $past(aboveUndervoltage, 2))
    else $error("buck enabled below undervoltage");
  chk_batt_stop: assert property (batteryLow [*4] |-> !boostEnable)
    else $error("boost kept on low battery");
  chk_volt_boost: assert property (boostVoltage != pbm_pkg::VSEL_5V |-> boostEnable)
    else $error("raised voltage without boost");
endmodule

bind pbm_mode_ctrl pbm_mode_props #(.LONG_CYC(LONG_CYC), .SETTLE_CYC(SETTLE_CYC))
  pbm_mode_props_inst (.clk, .rst_n, .inputPlugPresent, .aboveUndervoltage,
  .secondOutputSense, .batteryLow, .railReady, .operating, .buckEnable, .boostEnable,
  .boostVoltage, .firstPathEnable, .secondPathEnable, .externalBoosterEnable);

// ===== pbm_port_ic_model.sv
// Behavioural port control IC and boost rail for the mode controller bench
`timescale 1ns/1ns
module pbm_port_ic_model #(
  parameter int RAMP_CYC = 3,
  // Advertised source current in mA at 5 V, shown by Rp while unattached as source
  parameter int RP_MA    = 3000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Plug stimulus and supply level
  input  wire logic sourceAttach,
  input  wire logic sinkAttach,
  input  wire logic aboveUndervoltage,
  input  wire logic boostEnable,
  // Status back to the controller
  output logic      railReady,
  output logic      portAttachedSink,
  output logic      portAttachedSource
);
  typedef enum logic [2:0] {PBM_USRC, PBM_USNK, PBM_WSNK, PBM_WSRC, PBM_ASNK, PBM_ASRC} pbm_cc_t;
  pbm_cc_t st;
  int      railCnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= PBM_USRC;
      railCnt <= 0;
    end else begin
      // Rail collapses at once when boost stops, so no stale ready survives
      railCnt <= boostEnable ? railCnt + int'(railCnt < RAMP_CYC) : 0;
      case (st)
        PBM_USRC: st <= sinkAttach ? PBM_WSRC : PBM_USNK;
        PBM_USNK: st <= sourceAttach ? PBM_WSNK : PBM_USRC;
        PBM_WSNK: st <= !sourceAttach ? PBM_USNK :
                        (aboveUndervoltage ? PBM_ASNK : PBM_WSNK);
        PBM_WSRC: st <= sinkAttach ? PBM_ASRC : PBM_USRC;
        PBM_ASNK: st <= sourceAttach ? PBM_ASNK : PBM_USNK;
        default:  st <= sinkAttach ? PBM_ASRC : PBM_USRC;
      endcase
    end
  end

  assign railReady          = railCnt == RAMP_CYC;
  assign portAttachedSink   = st == PBM_ASNK;
  assign portAttachedSource = st == PBM_ASRC;
endmodule

// ===== tb_top.sv
// Self-checking bench for the power bank mode controller
`timescale 1ns/1ns
module tb_top;
  localparam int LONG  = 20;
  localparam int LIMIT = 5000;
  logic        clk, rst_n, typeCFirmware, inputPlugPresent, aboveWakeDetect;
  logic        aboveUndervoltage, firstOutputSense, secondOutputSense, batteryLow, button;
  logic        firstBelowTermCurrent, secondBelowTermCurrent, sourceAttach, sinkAttach;
  logic        railReady, portAttachedSink, portAttachedSource;
  logic [1:0]  fastChargeRequest, boostVoltage;
  logic        operating, buckEnable, boostEnable, firstPathEnable, secondPathEnable;
  logic        externalBoosterEnable, fastChargeEnable;
  logic [5:0]  modeOut;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  // Stimulus {typeC, inPlug, wake, uv, sense1, sense2, battLow, srcAttach, sinkAttach}
  // beside {operating, buck, boost, path1, path2, booster}
  logic [14:0] rows [0:12] = '{{9'h000, 6'h00}, {9'h0E0, 6'h30}, {9'h0C0, 6'h20},
    {9'h010, 6'h2C}, {9'h008, 6'h2B}, {9'h0F8, 6'h30}, {9'h014, 6'h00}, {9'h101, 6'h2C},
    {9'h122, 6'h30}, {9'h108, 6'h2B}, {9'h109, 6'h2F}, {9'h12A, 6'h30}, {9'h120, 6'h00}};

  assign modeOut = {operating, buckEnable, boostEnable, firstPathEnable, secondPathEnable,
                    externalBoosterEnable};

  pbm_mode_ctrl #(.LONG_CYC(LONG), .SETTLE_CYC(4)) pbm_mode_ctrl_inst (.clk, .rst_n,
    .typeCFirmware, .inputPlugPresent, .aboveWakeDetect, .aboveUndervoltage,
    .firstOutputSense, .secondOutputSense, .firstBelowTermCurrent, .secondBelowTermCurrent,
    .batteryLow, .button, .portAttachedSink, .portAttachedSource, .fastChargeRequest,
    .railReady, .operating, .buckEnable, .boostEnable, .boostVoltage, .firstPathEnable,
    .secondPathEnable, .externalBoosterEnable, .fastChargeEnable);

  pbm_port_ic_model pbm_port_ic_model_inst (.clk, .rst_n, .sourceAttach, .sinkAttach,
    .aboveUndervoltage, .boostEnable, .railReady, .portAttachedSink, .portAttachedSource);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic checkMode(input string name, input logic [5:0] exp, input logic [5:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic checkFlag(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic checkVsel(input string name, input logic [1:0] exp, input logic [1:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Called at a falling edge; holds the levels for n cycles
  task automatic step(input logic [8:0] v, input int n);
    {typeCFirmware, inputPlugPresent, aboveWakeDetect, aboveUndervoltage, firstOutputSense,
     secondOutputSense, batteryLow, sourceAttach, sinkAttach} = v;
    repeat (n) @(negedge clk);
  endtask

  task automatic doReset(input int n = 2);
    rst_n = 1'b0;
    button = 1'b0;
    firstBelowTermCurrent = 1'b0;
    secondBelowTermCurrent = 1'b0;
    fastChargeRequest = 2'h0;
    step(9'h000, n);
    rst_n = 1'b1;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    doReset(16);
    for (int i = 0; i < 13; i++) begin
      doReset();
      step(rows[i][14:6], 25);
      checkMode("row", rows[i][5:0], modeOut);
    end
    doReset();
    step(9'h010, 20);
    for (int c = 0; c < 4; c++) begin
      fastChargeRequest = c[1:0];
      repeat (6) @(negedge clk);
      checkVsel("boostVoltage", c[1:0], boostVoltage);
    end
    checkFlag("fastCharge", 1'b1, fastChargeEnable);
    step(9'h018, 20);
    checkVsel("twoPortVoltage", pbm_pkg::VSEL_5V, boostVoltage);
    checkMode("twoPorts", 6'h2F, modeOut);
    secondBelowTermCurrent = 1'b1;
    step(9'h018, 10);
    checkMode("lowCurrent", 6'h2C, modeOut);
    secondBelowTermCurrent = 1'b0;
    step(9'h018, 10);
    checkMode("latchedOff", 6'h2C, modeOut);
    // A long press is the only way back short of re-plugging
    button = 1'b1;
    step(9'h018, LONG + 8);
    button = 1'b0;
    step(9'h018, 20);
    checkMode("longPress", 6'h2F, modeOut);
    step(9'h01C, 10);
    checkMode("batteryLow", 6'h00, modeOut);
    doReset();
    button = 1'b1;
    step(9'h000, 5);
    button = 1'b0;
    step(9'h000, 20);
    checkMode("shortPress", 6'h00, modeOut);
    doReset();
    step(9'h010, 20);
    step(9'h0D0, 10);
    checkMode("inputDuringBoost", 6'h20, modeOut);
    step(9'h0F0, 10);
    checkMode("inputAboveUv", 6'h30, modeOut);
    step(9'h000, 10);
    checkMode("inputRemoved", 6'h00, modeOut);
    doReset();
    step(9'h018, 25);
    firstBelowTermCurrent = 1'b1;
    step(9'h018, 10);
    checkMode("firstLowCurrent", 6'h2B, modeOut);
    checkFlag("fastChargeOff", 1'b0, fastChargeEnable);
    // Reset in mid-boost must drop every output at once
    rst_n = 1'b0;
    @(negedge clk);
    checkMode("inReset", 6'h00, modeOut);
    checkVsel("resetVoltage", pbm_pkg::VSEL_5V, boostVoltage);
    doReset();
    step(9'h101, 25);
    step(9'h100, 10);
    checkMode("sinkDetached", 6'h00, modeOut);
    tally_and_finish();
  end
endmodule
